// file: rtl/rsp_ctrl.sv
`timescale 1ns/1ps
`include "rsp_defs.svh"
// Functional notes
// [R1] Converter stays powered in sleep if enabled
// [R2] First conversion after re-enable is extended; code holds converter_extended_out high from the first enable until rst_in
// [R3] Comparator off in deep sleep modes
// [R4] Comparator using reference keeps reference on
// [R5] Reference on when any user requests
// [R6] Brown-out fuse keeps detector on always
// [R7] Enabled watchdog keeps running in sleep
// [R8] Input buffers off when IO, converter clocks stop
// [R9] Debug fuse keeps main clock in deep sleep
// [R10] JTAG off by disable bit or fuse
// [R11] TDO undriven when TAP not shifting
// [R12] Reset loads initial values, restarts at vector
// [R13] Ports reset immediately on any source
// [R14] Delay counter stretches reset, fuse length
// [R15] Five reset sources accepted
// [R16] Long enough pin low level resets
// [R17] JTAG reset register holds device reset
// [R18] Watchdog gives one-cycle pulse, counts after
// [R19] Brown-out asserts immediately, releases via counter
// [R20] Supply drop re-asserts reset without delay
// [R21] Per-source sticky flags, zero-write clears
// [R22] Reset request is OR of sources
module rsp_ctrl
  import rsp_pkg::*;
#(
  parameter int PIN_MIN_CYC = `RSP_PIN_MIN_CYC
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     supply_low_in,
  input  wire logic                     reset_pin_n_in,
  input  wire logic                     watchdog_expire_in,
  input  wire logic                     brownout_low_in,
  input  wire logic                     jtag_reset_reg_in,
  input  wire logic                     brownout_enable_fuse_in,
  input  wire logic                     brownout_level_fuse_in,
  input  wire logic                     debug_enable_fuse_in,
  input  wire logic                     jtag_enable_fuse_in,
  input  wire logic [1:0]               clock_select_fuses_in,
  input  wire logic                     sleep_in,
  input  rsp_pkg::rsp_sleep_t           sleep_mode_in,
  input  wire logic                     converter_enable_in,
  input  wire logic                     comparator_disable_in,
  input  wire logic                     comparator_use_vref_in,
  input  wire logic                     watchdog_enable_in,
  input  wire logic                     wake_input_need_in,
  input  wire logic                     tap_shifting_in,
  input  wire logic                     tdo_data_in,
  input  wire logic                     jtag_disable_bit_wr_in,
  input  wire logic                     jtag_disable_bit_in,
  input  wire logic                     flags_wr_in,
  input  wire logic [`RSP_FLAG_W-1:0]   flags_wdata_in,
  output logic                          core_reset_out,
  output logic                          port_reset_out,
  output logic                          fetch_vector_out,
  output logic [`RSP_FLAG_W-1:0]        mcu_control_status_reg_out,
  output rsp_pkg::rsp_pwr_t             power_out,
  output logic                          brownout_level_out,
  output logic                          converter_extended_out,
  output logic                          jtag_enabled_out,
  output logic                          tdo_out,
  output logic                          tdo_oe_out
);
  import rsp_pkg::*;

  // ----------------------------------------
  // Reset sources
  // ----------------------------------------
  rsp_src_t   src;
  logic       req;
  logic [$clog2(PIN_MIN_CYC+1)-1:0] pin_cnt_reg, pin_cnt_next;
  logic       pin_rst;

  // Pin low filter: level counts only once long enough
  always_comb begin
    pin_cnt_next = pin_cnt_reg;
    if (reset_pin_n_in) begin
      pin_cnt_next = '0;
    end else if (pin_cnt_reg != PIN_MIN_CYC[$bits(pin_cnt_reg)-1:0]) begin
      pin_cnt_next = pin_cnt_reg + 1'b1;
    end
  end
  assign pin_rst = !reset_pin_n_in &&
                   (pin_cnt_reg == PIN_MIN_CYC[$bits(pin_cnt_reg)-1:0]); // R16

  // Source bundle and OR
  always_comb begin
    src.supply   = supply_low_in;                               // R20
    src.pin      = pin_rst;                                     // R16
    src.watchdog = watchdog_expire_in && watchdog_enable_in;    // R18
    src.brownout = brownout_low_in && brownout_enable_fuse_in;  // R19
    src.jtag     = jtag_reset_reg_in;                           // R17
  end
  assign req = |src; // R22 R15

  // ----------------------------------------
  // Delay counter sequencer
  // ----------------------------------------
  rsp_state_t              st_reg, st_next;
  logic [`RSP_TOUT_W-1:0]  dly_reg, dly_next;
  logic [`RSP_TOUT_W-1:0]  tout_len;

  // Fuse-selected time-out length
  function automatic logic [`RSP_TOUT_W-1:0] tout_sel(input logic [1:0] sel);
    case (sel)
      2'd0:    tout_sel = `RSP_TOUT_SHORT;
      2'd1:    tout_sel = `RSP_TOUT_MID;
      default: tout_sel = `RSP_TOUT_LONG;
    endcase
  endfunction : tout_sel

  assign tout_len = tout_sel(clock_select_fuses_in); // R14

  // Next state: any source holds, release starts count
  always_comb begin
    st_next  = st_reg;
    dly_next = dly_reg;
    case (st_reg)
      RSP_ST_HOLD: begin
        dly_next = '0;
        if (!req) begin
          st_next = RSP_ST_STRETCH; // R14 R18
        end
      end
      RSP_ST_STRETCH: begin
        if (req) begin
          st_next  = RSP_ST_HOLD;
          dly_next = '0;
        end else if (dly_reg == tout_len - 1'b1) begin
          st_next = RSP_ST_RUN; // R14
        end else begin
          dly_next = dly_reg + 1'b1;
        end
      end
      default: begin
        if (req) begin
          st_next = RSP_ST_HOLD; // R19 R20
        end
      end
    endcase
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  logic [`RSP_FLAG_W-1:0] flags_reg, flags_next;
  logic [`RSP_FLAG_W-1:0] src_vec;
  assign src_vec = src;

  // Set wins over software zero-write; supply reset clears others
  always_comb begin
    flags_next = flags_reg;
    if (flags_wr_in) begin
      flags_next = flags_reg & flags_wdata_in; // R21
    end
    if (src.supply) begin
      flags_next = `RSP_FLAGS_RESET; // R21
    end else begin
      flags_next = flags_next | src_vec; // R21
    end
  end

  // ----------------------------------------
  // Power gating
  // ----------------------------------------
  logic      jtd_reg, jtd_next;
  logic      conv_prev_reg, conv_pend_reg, conv_pend_next;
  logic      deep;
  logic      io_adc_stop;
  rsp_pwr_t  pwr;

  assign deep        = sleep_in && (sleep_mode_in != RSP_SLP_IDLE) &&
                       (sleep_mode_in != RSP_SLP_NOISE);
  assign io_adc_stop = deep;
  always_comb begin
    jtd_next = jtd_reg;
    if (jtag_disable_bit_wr_in) begin
      jtd_next = jtag_disable_bit_in;
    end
    conv_pend_next = conv_pend_reg;
    if (converter_enable_in && !conv_prev_reg) begin
      conv_pend_next = 1'b1; // R2
    end else if (!converter_enable_in) begin
      conv_pend_next = conv_pend_reg;
    end
    pwr.converter  = converter_enable_in;                                   // R1
    pwr.comparator = !comparator_disable_in && !deep;                       // R3
    pwr.vref       = brownout_enable_fuse_in || converter_enable_in ||
                     (comparator_use_vref_in && !comparator_disable_in);    // R4 R5
    pwr.brownout   = brownout_enable_fuse_in;                               // R6
    pwr.watchdog   = watchdog_enable_in;                                    // R7
    pwr.main_clock = !(sleep_in && (sleep_mode_in == RSP_SLP_PDOWN ||
                     sleep_mode_in == RSP_SLP_PSAVE)) ||
                     (debug_enable_fuse_in && jtag_enable_fuse_in && !jtd_reg); // R9
    pwr.input_buf  = !io_adc_stop || wake_input_need_in;                    // R8
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin_cnt_reg   <= '0;
      st_reg        <= RSP_ST_HOLD;
      dly_reg       <= '0;
      flags_reg     <= `RSP_FLAGS_RESET;
      jtd_reg       <= 1'b0;
      conv_prev_reg <= 1'b0;
      conv_pend_reg <= 1'b0;
    end else begin
      pin_cnt_reg   <= pin_cnt_next;
      st_reg        <= st_next;
      dly_reg       <= dly_next;
      flags_reg     <= flags_next;
      jtd_reg       <= req ? 1'b0 : jtd_next; // R12
      conv_prev_reg <= converter_enable_in;
      conv_pend_reg <= conv_pend_next;
    end
  end

  // Output registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      core_reset_out             <= 1'b1;
      port_reset_out             <= 1'b1;
      fetch_vector_out           <= 1'b0;
      mcu_control_status_reg_out <= `RSP_FLAGS_RESET;
      power_out                  <= '0;
      brownout_level_out         <= 1'b0;
      converter_extended_out     <= 1'b0;
      jtag_enabled_out           <= 1'b0;
      tdo_out                    <= 1'b0;
      tdo_oe_out                 <= 1'b0;
    end else begin
      core_reset_out             <= (st_next != RSP_ST_RUN);          // R12 R14
      port_reset_out             <= req || (st_next != RSP_ST_RUN);   // R13
      fetch_vector_out           <= (st_reg == RSP_ST_STRETCH) &&
                                    (st_next == RSP_ST_RUN);          // R12
      mcu_control_status_reg_out <= flags_next;
      power_out                  <= pwr;
      brownout_level_out         <= brownout_level_fuse_in;           // R19
      converter_extended_out     <= conv_pend_next;                   // R2
      jtag_enabled_out           <= jtag_enable_fuse_in && !jtd_next; // R10
      tdo_out                    <= tdo_data_in;
      tdo_oe_out                 <= jtag_enable_fuse_in && !jtd_next &&
                                    tap_shifting_in;                  // R11
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Reset held on two edges after the last source drops
  sequence held_two_s;
    core_reset_out ##1 core_reset_out;
  endsequence

  // Final count of the stretch with no source active
  sequence last_count_s;
    (st_reg == RSP_ST_STRETCH) && !req && (dly_reg == tout_len - 1'b1);
  endsequence

  hold_on_req_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R22
    req |=> core_reset_out) else $error("reset not held while source active");
  port_now_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R13
    req |=> port_reset_out) else $error("ports not reset on source");
  jtag_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R17
    jtag_reset_reg_in && !supply_low_in |=> core_reset_out && flags_reg[`RSP_FLAG_JTAG])
    else $error("jtag reset not held");
  stretch_min_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R14
    $fell(req) |=> held_two_s) else $error("reset not stretched");
  tdo_float_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R11
    !tap_shifting_in |=> !tdo_oe_out) else $error("tdo driven while idle");
  jtag_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R10
    !jtag_enable_fuse_in |=> !jtag_enabled_out) else $error("jtag enabled without fuse");
  bod_on_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R6
    brownout_enable_fuse_in |=> power_out.brownout && power_out.vref)
    else $error("brown-out detector off");
  cmp_deep_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R3
    deep |=> !power_out.comparator) else $error("comparator on in deep sleep");
  wdg_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R18
    src.watchdog && !src.supply |=> flags_reg[`RSP_FLAG_WATCHDOG])
    else $error("watchdog flag not set");
  supply_clr_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R20
    src.supply |=> flags_reg == `RSP_FLAGS_RESET) else $error("supply flag pattern wrong");
  release_vec_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R14
    last_count_s |=> !core_reset_out && fetch_vector_out)
    else $error("reset not released after count");
  vec_pulse_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R12
    fetch_vector_out |=> !fetch_vector_out)
    else $error("vector fetch longer than one cycle");
  conv_keep_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R1
    converter_enable_in |=> power_out.converter && power_out.vref)
    else $error("converter or reference dropped");
  vref_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R5
    !brownout_enable_fuse_in && !converter_enable_in && comparator_disable_in |=>
    !power_out.vref) else $error("reference on with no user");
  wdg_run_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R7
    watchdog_enable_in |=> power_out.watchdog) else $error("watchdog stopped");
  buf_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R8
    io_adc_stop && !wake_input_need_in |=> !power_out.input_buf)
    else $error("input buffers on in deep sleep");
  dbg_clock_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // R9
    debug_enable_fuse_in && jtag_enable_fuse_in && !jtd_reg |=> power_out.main_clock)
    else $error("main clock stopped with debug on");

endmodule : rsp_ctrl

// file: rtl/rsp_defs.svh
`ifndef RSP_DEFS_SVH
`define RSP_DEFS_SVH

// ----------------------------------------
// Reset flag bit positions
// ----------------------------------------
`define RSP_FLAG_SUPPLY   0
`define RSP_FLAG_PIN      1
`define RSP_FLAG_BROWNOUT 2
`define RSP_FLAG_WATCHDOG 3
`define RSP_FLAG_JTAG     4
`define RSP_FLAG_W        5

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RSP_FLAGS_RESET   5'h01
`define RSP_CLK_MHZ       10
`define RSP_PIN_MIN_NS    1500
`define RSP_PIN_MIN_CYC   ((`RSP_PIN_MIN_NS * `RSP_CLK_MHZ + 999) / 1000)
`define RSP_TOUT_SHORT    16'h0010
`define RSP_TOUT_MID      16'h0400
`define RSP_TOUT_LONG     16'h4000
`define RSP_TOUT_W        16

`endif

// file: rtl/rsp_pkg.sv
package rsp_pkg;

  // Sleep mode encoding
  typedef enum logic [2:0] {
    RSP_SLP_IDLE     = 3'h0,
    RSP_SLP_NOISE    = 3'h1,
    RSP_SLP_PDOWN    = 3'h2,
    RSP_SLP_PSAVE    = 3'h3,
    RSP_SLP_STANDBY  = 3'h6,
    RSP_SLP_XSTANDBY = 3'h7
  } rsp_sleep_t;

  // Sequencer states, Gray along the path
  typedef enum logic [1:0] {
    RSP_ST_HOLD    = 2'b00,
    RSP_ST_STRETCH = 2'b01,
    RSP_ST_RUN     = 2'b11
  } rsp_state_t;

  // Reset source bundle
  typedef struct packed {
    logic jtag;
    logic watchdog;
    logic brownout;
    logic pin;
    logic supply;
  } rsp_src_t;

  // Power enable bundle
  typedef struct packed {
    logic converter;
    logic comparator;
    logic vref;
    logic brownout;
    logic watchdog;
    logic main_clock;
    logic input_buf;
  } rsp_pwr_t;

endpackage : rsp_pkg

// file: tb/rsp_far.sv
`timescale 1ns/1ps
// ---
// Supply monitors, reset pin and JTAG side
// ---
module rsp_far (
  input  wire logic clk_in,
  output logic      supply_low_out,
  output logic      reset_pin_n_out,
  output logic      watchdog_expire_out,
  output logic      brownout_low_out,
  output logic      jtag_reset_reg_out,
  output logic      tap_shifting_out,
  output logic      tdo_data_out
);
  logic shift_bit;
  // Quiet lines at time zero
  initial begin
    {supply_low_out, watchdog_expire_out, brownout_low_out} = 3'h0;
    {jtag_reset_reg_out, tap_shifting_out, tdo_data_out, shift_bit} = 4'h0;
    reset_pin_n_out = 1'b1;
  end
  // Data line churns while the TAP is idle
  always @(negedge clk_in) begin
    tdo_data_out <= tap_shifting_out ? shift_bit : ~tdo_data_out;
  end
  // Raise or drop one reset source
  task automatic src(input int i, input logic on);
    @(negedge clk_in);
    case (i)
      0: supply_low_out = on;
      1: reset_pin_n_out = ~on;
      2: brownout_low_out = on;
      3: watchdog_expire_out = on;
      default: jtag_reset_reg_out = on;
    endcase
  endtask : src
  // One clock wide expiry pulse
  task automatic wdg_pulse;
    src(3, 1'b1);
    src(3, 1'b0);
  endtask : wdg_pulse
  // Start or stop shifting
  task automatic shift(input logic on, input logic d);
    @(negedge clk_in);
    tap_shifting_out = on;
    shift_bit = d;
  endtask : shift
endmodule : rsp_far

// file: tb/rsp_ctrl_test.sv
`timescale 1ns/1ps
// ---
// Self-checking bench for the reset and power controller
// ---
module rsp_ctrl_test;
  import rsp_pkg::*;
  localparam int PIN_CYC = 2;
  logic core_clk_in, rst_in, supply_low_in, reset_pin_n_in, watchdog_expire_in;
  logic brownout_low_in, jtag_reset_reg_in, brownout_enable_fuse_in, brownout_level_fuse_in;
  logic debug_enable_fuse_in, jtag_enable_fuse_in, sleep_in, converter_enable_in;
  logic comparator_disable_in, comparator_use_vref_in, watchdog_enable_in, wake_input_need_in;
  logic tap_shifting_in, tdo_data_in, jtag_disable_bit_wr_in, jtag_disable_bit_in, flags_wr_in;
  logic [1:0] clock_select_fuses_in;
  logic [4:0] flags_wdata_in, mcu_control_status_reg_out, exp_f;
  logic core_reset_out, port_reset_out, fetch_vector_out, brownout_level_out;
  logic converter_extended_out, jtag_enabled_out, tdo_out, tdo_oe_out;
  rsp_sleep_t sleep_mode_in;
  rsp_pwr_t   power_out, exp_p;
  rsp_sleep_t modes[6] = '{RSP_SLP_IDLE, RSP_SLP_NOISE, RSP_SLP_PDOWN, RSP_SLP_PSAVE,
                           RSP_SLP_STANDBY, RSP_SLP_XSTANDBY};
  int tout[3] = '{16, 1024, 16384};
  int miscompares, checks, n;

  rsp_ctrl #(.PIN_MIN_CYC(PIN_CYC)) uut (.core_clk_in, .rst_in, .supply_low_in, .reset_pin_n_in,
    .watchdog_expire_in, .brownout_low_in, .jtag_reset_reg_in, .brownout_enable_fuse_in,
    .brownout_level_fuse_in, .debug_enable_fuse_in, .jtag_enable_fuse_in, .clock_select_fuses_in,
    .sleep_in, .sleep_mode_in, .converter_enable_in, .comparator_disable_in,
    .comparator_use_vref_in, .watchdog_enable_in, .wake_input_need_in, .tap_shifting_in,
    .tdo_data_in, .jtag_disable_bit_wr_in, .jtag_disable_bit_in, .flags_wr_in, .flags_wdata_in,
    .core_reset_out, .port_reset_out, .fetch_vector_out, .mcu_control_status_reg_out, .power_out,
    .brownout_level_out, .converter_extended_out, .jtag_enabled_out, .tdo_out, .tdo_oe_out);
  rsp_far far (.clk_in(core_clk_in), .supply_low_out(supply_low_in),
    .reset_pin_n_out(reset_pin_n_in), .watchdog_expire_out(watchdog_expire_in),
    .brownout_low_out(brownout_low_in), .jtag_reset_reg_out(jtag_reset_reg_in),
    .tap_shifting_out(tap_shifting_in), .tdo_data_out(tdo_data_in));

  // 10 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : chk
  // Verdict and end of run
  task automatic wrap_up;
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_in);
  endtask : cyc
  // Wait for the core to leave reset, counting edges
  task automatic wait_rel;
    n = 0;
    while (core_reset_out !== 1'b0) begin
      @(negedge core_clk_in);
      n++;
      if (n > 20000) begin
        miscompares++;
        wrap_up();
      end
    end
  endtask : wait_rel
  // One-cycle write of the flags or the JTAG disable bit
  task automatic wr(input logic sel, input logic [4:0] v);
    flags_wdata_in = v;
    jtag_disable_bit_in = v[0];
    {jtag_disable_bit_wr_in, flags_wr_in} = {sel, ~sel};
    cyc(1);
    {jtag_disable_bit_wr_in, flags_wr_in} = 2'b00;
    cyc(1);
  endtask : wr

  // Main sequence
  initial begin
    {rst_in, brownout_enable_fuse_in, jtag_enable_fuse_in, watchdog_enable_in} = 4'hf;
    {brownout_level_fuse_in, debug_enable_fuse_in, sleep_in, converter_enable_in} = 4'h0;
    {comparator_disable_in, comparator_use_vref_in, wake_input_need_in} = 3'h0;
    {jtag_disable_bit_wr_in, jtag_disable_bit_in, flags_wr_in} = 3'h0;
    {clock_select_fuses_in, flags_wdata_in} = 7'h0;
    sleep_mode_in = RSP_SLP_IDLE;
    miscompares = 0;
    checks = 0;
    cyc(3);
    rst_in = 1'b0;
    chk(mcu_control_status_reg_out, 5'h01, "flags after reset");
    chk(core_reset_out, 1'b1, "core held in reset");
    wait_rel();
    // Supply drop and recovery at each delay length
    foreach (tout[k]) begin
      clock_select_fuses_in = k[1:0];
      far.src(0, 1'b1);
      cyc(1);
      chk(port_reset_out, 1'b1, "port reset");
      far.src(0, 1'b0);
      wait_rel();
      chk(n, tout[k] + 1, "stretch length");
      chk(fetch_vector_out, 1'b1, "vector fetch");
      cyc(1);
      chk(fetch_vector_out, 1'b0, "vector pulse width");
    end
    clock_select_fuses_in = 2'h0;
    wr(1'b0, 5'h00);
    chk(mcu_control_status_reg_out, 5'h00, "flags cleared");
    // Pin, brown-out, watchdog and JTAG sources one by one
    exp_f = 5'h00;
    for (int i = 1; i < 5; i++) begin
      if (i == 3) far.wdg_pulse();
      else far.src(i, 1'b1);
      if (i != 3) cyc(PIN_CYC + 38);
      chk({core_reset_out, port_reset_out}, 2'b11, "source reset");
      if (i != 3) far.src(i, 1'b0);
      wait_rel();
      chk(n, tout[0] + 1, "stretch after source");
      exp_f[i] = 1'b1;
      cyc(1);
      chk(mcu_control_status_reg_out, exp_f, "source flag");
    end
    far.src(0, 1'b1);
    far.src(0, 1'b0);
    wait_rel();
    chk(mcu_control_status_reg_out, 5'h01, "supply clears flags");
    far.src(1, 1'b1);
    far.src(1, 1'b0);
    cyc(3);
    chk({port_reset_out, mcu_control_status_reg_out}, 6'h01, "short pin pulse");
    // Gated sources: brown-out fuse off, watchdog disabled; level fuse passes
    {brownout_enable_fuse_in, brownout_level_fuse_in, watchdog_enable_in} = 3'b010;
    far.src(2, 1'b1);
    far.wdg_pulse();
    cyc(1);
    chk({port_reset_out, mcu_control_status_reg_out}, 6'h01, "gated sources");
    chk(brownout_level_out, 1'b1, "level fuse");
    far.src(2, 1'b0);
    {brownout_enable_fuse_in, watchdog_enable_in} = 2'b11;
    // Power gating over every sleep mode
    chk(converter_extended_out, 1'b0, "no extension yet");
    sleep_in = 1'b1;
    foreach (modes[m]) for (int v = 0; v < 8; v++) begin
      sleep_mode_in = modes[m];
      {converter_enable_in, comparator_disable_in, comparator_use_vref_in} = {v[0], v[1], v[2]};
      {brownout_enable_fuse_in, watchdog_enable_in} = {v[1] & v[0], v[2]};
      {wake_input_need_in, debug_enable_fuse_in} = {v[0], v[1]};
      cyc(2);
      exp_p.converter = v[0];
      exp_p.comparator = !v[1] && modes[m] inside {RSP_SLP_IDLE, RSP_SLP_NOISE};
      exp_p.vref = (v[1] & v[0]) | v[0] | (v[2] & !v[1]);
      exp_p.brownout = v[1] & v[0];
      exp_p.watchdog = v[2];
      exp_p.main_clock = !(modes[m] inside {RSP_SLP_PDOWN, RSP_SLP_PSAVE}) | v[1];
      exp_p.input_buf = modes[m] inside {RSP_SLP_IDLE, RSP_SLP_NOISE} | v[0];
      chk(power_out, exp_p, "power enables");
    end
    chk(converter_extended_out, 1'b1, "extended conversion");
    // JTAG enable and TDO drive
    far.shift(1'b0, 1'b0);
    cyc(2);
    chk({jtag_enabled_out, tdo_oe_out}, 2'b10, "TDO idle undriven");
    far.shift(1'b1, 1'b1);
    cyc(2);
    chk({tdo_oe_out, tdo_out}, 2'b11, "TDO shifting");
    wr(1'b1, 5'h01);
    chk({jtag_enabled_out, tdo_oe_out}, 2'b00, "disable bit");
    sleep_mode_in = RSP_SLP_PDOWN;
    cyc(2);
    chk(power_out.main_clock, 1'b0, "debug clock off");
    wr(1'b1, 5'h00);
    jtag_enable_fuse_in = 1'b0;
    cyc(2);
    chk(jtag_enabled_out, 1'b0, "fuse unprogrammed");
    wrap_up();
  end
endmodule : rsp_ctrl_test
